/* File: ra2dm_pkg.sv */
// Package: register map, field layout and types for the alarm-2 date match block
// Notes on behaviour
// - Bit 7 enables matching on each field.
// - Month field bits 4:0 matches month counter.
// - Year field bits 6:0 matches year counter.
// - Month bits 6,5 and day bit 6 unstored.
// - Day field bits 5:0 matches day counter.
package ra2dm_pkg;

  // ----------------------------------------------------------------
  // Register indices and byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_MONTH = 8'h19;
  localparam logic [7:0] IDX_YEAR = 8'h1a;
  localparam logic [7:0] IDX_DOM = 8'h1b;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h20;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h21;
  localparam logic [9:0] ADDR_MONTH = {IDX_MONTH, 2'b00};
  localparam logic [9:0] ADDR_YEAR = {IDX_YEAR, 2'b00};
  localparam logic [9:0] ADDR_DOM = {IDX_DOM, 2'b00};
  localparam logic [9:0] ADDR_IRQ_STATUS = {IDX_IRQ_STATUS, 2'b00};
  localparam logic [9:0] ADDR_IRQ_MASK = {IDX_IRQ_MASK, 2'b00};

  // ----------------------------------------------------------------
  // Field layout and reset values
  // ----------------------------------------------------------------
  localparam int ENABLE_BIT = 7;
  localparam int MONTH_W = 5;
  localparam int YEAR_W = 7;
  localparam int DOM_W = 6;
  localparam logic [7:0] RESET_MONTH = 8'h00;
  localparam logic [7:0] RESET_YEAR = 8'h00;
  localparam logic [7:0] RESET_DOM = 8'h00;
  localparam logic RESET_IRQ_STATUS = 1'b0;
  localparam logic RESET_IRQ_MASK = 1'b0;

  // Running calendar counters from the clock unit
  typedef struct packed {
    logic [MONTH_W-1:0] month;
    logic [YEAR_W-1:0] year;
    logic [DOM_W-1:0] dom;
  } ra2dm_cal_s;

endpackage

/* File: ra2dm_properties.sv */
// Checker for the alarm-2 date match block, bound to its top module
module ra2dm_properties (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire ra2dm_pkg::ra2dm_cal_s cal,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic alarm2_match
);
  localparam logic [11:0] A_M = {2'b00, ra2dm_pkg::ADDR_MONTH};
  localparam logic [11:0] A_Y = {2'b00, ra2dm_pkg::ADDR_YEAR};
  localparam logic [11:0] A_D = {2'b00, ra2dm_pkg::ADDR_DOM};
  logic [7:0] mon_q, yr_q, dom_q;
  logic wr_ok, hit;
  // Shadow copies taken at the access edge, where the block commits writes
  assign wr_ok = psel && penable && pready && pwrite && pstrb[0] && clk_en;
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      mon_q <= 8'h00;
      yr_q <= 8'h00;
      dom_q <= 8'h00;
    end else if (wr_ok) begin
      if (paddr == A_M) mon_q <= pwdata[7:0];
      if (paddr == A_Y) yr_q <= pwdata[7:0];
      if (paddr == A_D) dom_q <= pwdata[7:0];
    end
  end
  assign hit = (mon_q[7] | yr_q[7] | dom_q[7]) && (!mon_q[7] || mon_q[4:0] == cal.month)
    && (!yr_q[7] || yr_q[6:0] == cal.year) && (!dom_q[7] || dom_q[5:0] == cal.dom);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  sequence s_setup;
    psel && !penable && clk_en;
  endsequence
  sequence s_live;
    $past(clk_en) && alarm2_match;
  endsequence
  ready_after_setup_a: assert property (s_setup |=> pready) else $error("no ready after setup");
  error_with_ready_a: assert property (pslverr |-> pready) else $error("error without ready");
  match_all_a: assert property ($past(clk_en) |-> alarm2_match == $past(hit))
    else $error("match flag disagrees with enabled fields");
  month_cmp_a: assert property (s_live ##0 $past(mon_q[7]) |->
    $past(mon_q[4:0]) == $past(cal.month)) else $error("month mismatch while matched");
  year_cmp_a: assert property (s_live ##0 $past(yr_q[7]) |->
    $past(yr_q[6:0]) == $past(cal.year)) else $error("year mismatch while matched");
  dom_cmp_a: assert property (s_live ##0 $past(dom_q[7]) |->
    $past(dom_q[5:0]) == $past(cal.dom)) else $error("day mismatch while matched");
  all_off_quiet_a: assert property ($past(clk_en) && !$past(mon_q[7] | yr_q[7] | dom_q[7])
    |-> !alarm2_match) else $error("match with every field disabled");
  unstored_zero_a: assert property (pready && !pwrite |->
    !(paddr == A_M && prdata[6:5] != 2'b00) && !(paddr == A_D && prdata[6]))
    else $error("unstored bit read as one");
endmodule
bind ra2dm_top ra2dm_properties u_props (.clk_sys, .sys_rst, .clk_en, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pstrb, .cal, .prdata, .pready, .pslverr, .alarm2_match);

/* File: ra2dm_tb.sv */
// Self-checking testbench for the alarm-2 date match block
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] A_M = {2'b00, ra2dm_pkg::ADDR_MONTH};
  localparam logic [11:0] A_Y = {2'b00, ra2dm_pkg::ADDR_YEAR};
  localparam logic [11:0] A_D = {2'b00, ra2dm_pkg::ADDR_DOM};
  localparam logic [11:0] A_S = {2'b00, ra2dm_pkg::ADDR_IRQ_STATUS};
  localparam logic [11:0] A_K = {2'b00, ra2dm_pkg::ADDR_IRQ_MASK};
  logic clk_sys = 1'b0, sys_rst = 1'b1, clk_en = 1'b1, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, pready, pslverr, second_alarm_interrupt, alarm2_match, err_q;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] pstrb = 4'hf;
  ra2dm_pkg::ra2dm_cal_s cal = '0;
  int err_total = 0, tests_run = 0;
  always #5 clk_sys = ~clk_sys;
  ra2dm_top DUT (.clk_sys, .sys_rst, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .cal, .prdata, .pready, .pslverr, .second_alarm_interrupt, .alarm2_match);
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  // Request held until pready is sampled high; answer taken at that edge
  task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    penable <= 1'b0;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    rd = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic scen(input logic [7:0] m, y, d, input logic [17:0] c, input logic e);
    xfer(1'b1, A_M, m);
    xfer(1'b1, A_Y, y);
    xfer(1'b1, A_D, d);
    cal <= ra2dm_pkg::ra2dm_cal_s'(c);
    repeat (3) @(posedge clk_sys);
    #1 chk("match", {31'h0, alarm2_match}, {31'h0, e});
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk_sys);
    sys_rst <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      xfer(1'b0, A_M + 12'(4 * i), 8'h00);
      chk("reset value", rd, 32'h0);
    end
    xfer(1'b1, A_M, 8'h9f);
    xfer(1'b0, A_M, 8'h00);
    chk("month readback", rd, 32'h9f);
    xfer(1'b1, A_D, 8'hbf);
    xfer(1'b0, A_D, 8'h00);
    chk("day readback", rd, 32'hbf);
    xfer(1'b1, A_Y, 8'hff);
    xfer(1'b0, A_Y, 8'h00);
    chk("year readback", rd, 32'hff);
    xfer(1'b1, A_K, 8'h01);
    scen(8'h00, 8'h00, 8'h00, 18'h0, 1'b0);
    scen(8'h85, 8'h00, 8'h00, {5'h05, 7'h33, 6'h11}, 1'b1);
    chk("irq raised", {31'h0, second_alarm_interrupt}, 32'h1);
    xfer(1'b1, A_K, 8'h00);
    @(posedge clk_sys);
    #1 chk("irq masked", {31'h0, second_alarm_interrupt}, 32'h0);
    xfer(1'b1, A_K, 8'h01);
    xfer(1'b1, A_S, 8'h01);
    xfer(1'b0, A_S, 8'h00);
    chk("status cleared", rd, 32'h0);
    #1 chk("irq cleared", {31'h0, second_alarm_interrupt}, 32'h0);
    scen(8'h86, 8'h00, 8'h00, {5'h05, 7'h33, 6'h11}, 1'b0);
    scen(8'h85, 8'hd5, 8'h00, {5'h05, 7'h54, 6'h11}, 1'b0);
    scen(8'h85, 8'hd5, 8'h00, {5'h05, 7'h55, 6'h11}, 1'b1);
    scen(8'h00, 8'h00, 8'h9f, {5'h02, 7'h00, 6'h1f}, 1'b1);
    scen(8'h00, 8'h00, 8'h9f, {5'h02, 7'h00, 6'h1e}, 1'b0);
    @(posedge clk_sys);
    clk_en <= 1'b0;
    cal <= ra2dm_pkg::ra2dm_cal_s'({5'h02, 7'h00, 6'h1f});
    repeat (3) @(posedge clk_sys);
    #1 chk("frozen match", {31'h0, alarm2_match}, 32'h0);
    @(posedge clk_sys);
    clk_en <= 1'b1;
    repeat (2) @(posedge clk_sys);
    #1 chk("thawed match", {31'h0, alarm2_match}, 32'h1);
    xfer(1'b0, 12'h0f0, 8'h00);
    chk("unmapped error", {31'h0, err_q}, 32'h1);
    wrap_up;
  end
  initial begin
    #100000;
    err_total++;
    wrap_up;
  end
endmodule

/* File: ra2dm_top.sv */
// Alarm-2 month, year and day-of-month match registers with APB access
module ra2dm_top (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire ra2dm_pkg::ra2dm_cal_s cal,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic second_alarm_interrupt,
  output logic alarm2_match
);

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  // Stored alarm fields, one enable and one value each
  logic alarm2_month_enable_q;
  logic [ra2dm_pkg::MONTH_W-1:0] alarm2_month_value_q;
  logic alarm2_year_enable_q;
  logic [ra2dm_pkg::YEAR_W-1:0] alarm2_year_value_q;
  logic alarm2_day_of_month_enable_q;
  logic [ra2dm_pkg::DOM_W-1:0] alarm2_day_of_month_value_q;
  // Interrupt state and the match seen at the previous enabled edge
  logic irq_status_q;
  logic irq_mask_q;
  logic match_prev_q;

  logic setup_d;
  logic access_d;
  logic wr_en;
  logic wr_month;
  logic wr_year;
  logic wr_dom;
  logic wr_status;
  logic wr_mask;
  logic mapped;
  logic [9:0] word_addr;
  logic match_now;
  logic match_rise;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // One register per aligned word; the two low byte-address bits are ignored
  function automatic logic hit(input logic [9:0] wa, input logic [7:0] idx);
    hit = (wa == {2'b00, idx});
  endfunction

  function automatic logic is_mapped(input logic [9:0] wa);
    is_mapped = hit(wa, ra2dm_pkg::IDX_MONTH) ||
                hit(wa, ra2dm_pkg::IDX_YEAR) ||
                hit(wa, ra2dm_pkg::IDX_DOM) ||
                hit(wa, ra2dm_pkg::IDX_IRQ_STATUS) ||
                hit(wa, ra2dm_pkg::IDX_IRQ_MASK);
  endfunction

  assign word_addr = paddr[11:2];
  assign setup_d = psel && !penable;
  assign mapped = is_mapped(word_addr);

  // Writes land at the edge where the master sees pready high;
  // a write whose access edge meets clk_en low is dropped, so keep
  // clk_en up for the whole transfer
  assign access_d = psel && penable && pready;
  assign wr_en = access_d && pwrite && pstrb[0] && clk_en;
  assign wr_month = wr_en && hit(word_addr, ra2dm_pkg::IDX_MONTH);
  assign wr_year = wr_en && hit(word_addr, ra2dm_pkg::IDX_YEAR);
  assign wr_dom = wr_en && hit(word_addr, ra2dm_pkg::IDX_DOM);
  assign wr_status = wr_en && hit(word_addr, ra2dm_pkg::IDX_IRQ_STATUS);
  assign wr_mask = wr_en && hit(word_addr, ra2dm_pkg::IDX_IRQ_MASK);

  // ----------------------------------------------------------------
  // Alarm field writes
  // ----------------------------------------------------------------
  // Month: enable plus five stored bits; bits 6:5 have no storage
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      alarm2_month_enable_q <= ra2dm_pkg::RESET_MONTH[ra2dm_pkg::ENABLE_BIT];
      alarm2_month_value_q <= ra2dm_pkg::RESET_MONTH[ra2dm_pkg::MONTH_W-1:0];
    end else if (wr_month) begin
      alarm2_month_enable_q <= pwdata[ra2dm_pkg::ENABLE_BIT];
      alarm2_month_value_q <= pwdata[ra2dm_pkg::MONTH_W-1:0];
    end
  end

  // Year: enable plus seven stored bits
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      alarm2_year_enable_q <= ra2dm_pkg::RESET_YEAR[ra2dm_pkg::ENABLE_BIT];
      alarm2_year_value_q <= ra2dm_pkg::RESET_YEAR[ra2dm_pkg::YEAR_W-1:0];
    end else if (wr_year) begin
      alarm2_year_enable_q <= pwdata[ra2dm_pkg::ENABLE_BIT];
      alarm2_year_value_q <= pwdata[ra2dm_pkg::YEAR_W-1:0];
    end
  end

  // Day of month: enable plus six stored bits; bit 6 has no storage
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      alarm2_day_of_month_enable_q <= ra2dm_pkg::RESET_DOM[ra2dm_pkg::ENABLE_BIT];
      alarm2_day_of_month_value_q <= ra2dm_pkg::RESET_DOM[ra2dm_pkg::DOM_W-1:0];
    end else if (wr_dom) begin
      alarm2_day_of_month_enable_q <= pwdata[ra2dm_pkg::ENABLE_BIT];
      alarm2_day_of_month_value_q <= pwdata[ra2dm_pkg::DOM_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Date compare
  // ----------------------------------------------------------------
  // A disabled field passes; with all fields off no alarm is raised at all
  // The calendar runs on this clock, so it is compared without synchronising
  always_comb begin
    match_now = (!alarm2_month_enable_q || alarm2_month_value_q == cal.month) &&
                (!alarm2_year_enable_q || alarm2_year_value_q == cal.year) &&
                (!alarm2_day_of_month_enable_q ||
                 alarm2_day_of_month_value_q == cal.dom) &&
                (alarm2_month_enable_q || alarm2_year_enable_q ||
                 alarm2_day_of_month_enable_q);
  end

  // ----------------------------------------------------------------
  // Match tracking
  // ----------------------------------------------------------------
  // Only the entry into a match is an event, so a held date does not re-fire
  // The previous match clears at reset, so a date already matching then fires
  assign match_rise = match_now && !match_prev_q;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      match_prev_q <= 1'b0;
      alarm2_match <= 1'b0;
    end else if (clk_en) begin
      match_prev_q <= match_now;
      alarm2_match <= match_now;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status and mask
  // ----------------------------------------------------------------
  // Sticky status bit, cleared by writing a one to bit 0
  // A new match in the clearing cycle keeps the bit set
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      irq_status_q <= ra2dm_pkg::RESET_IRQ_STATUS;
    end else if (clk_en) begin
      if (match_rise) begin
        irq_status_q <= 1'b1;
      end else if (wr_status && pwdata[0]) begin
        irq_status_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      irq_mask_q <= ra2dm_pkg::RESET_IRQ_MASK;
    end else if (wr_mask) begin
      irq_mask_q <= pwdata[0];
    end
  end

  // ----------------------------------------------------------------
  // Interrupt output
  // ----------------------------------------------------------------
  // Mask bit high lets the status through; output lags status by one cycle
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      second_alarm_interrupt <= 1'b0;
    end else if (clk_en) begin
      second_alarm_interrupt <= irq_status_q && irq_mask_q;
    end
  end

  // ----------------------------------------------------------------
  // APB response
  // ----------------------------------------------------------------
  // Zero wait states: every setup cycle with clk_en high is answered in the access cycle after it
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pready <= setup_d;
      pslverr <= setup_d && !mapped;
    end
  end

  // Read data is built at the setup edge so it stands through the access cycle;
  // unstored bits read as zero
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      prdata <= 32'h0000_0000;
    end else if (clk_en) begin
      prdata <= 32'h0000_0000;
      if (setup_d && !pwrite) begin
        if (hit(word_addr, ra2dm_pkg::IDX_MONTH)) begin
          prdata <= {24'h000000, alarm2_month_enable_q, 2'b00, alarm2_month_value_q};
        end
        if (hit(word_addr, ra2dm_pkg::IDX_YEAR)) begin
          prdata <= {24'h000000, alarm2_year_enable_q, alarm2_year_value_q};
        end
        if (hit(word_addr, ra2dm_pkg::IDX_DOM)) begin
          prdata <= {24'h000000, alarm2_day_of_month_enable_q, 1'b0,
                     alarm2_day_of_month_value_q};
        end
        if (hit(word_addr, ra2dm_pkg::IDX_IRQ_STATUS)) begin
          prdata <= {31'h0000_0000, irq_status_q};
        end
        if (hit(word_addr, ra2dm_pkg::IDX_IRQ_MASK)) begin
          prdata <= {31'h0000_0000, irq_mask_q};
        end
      end
    end
  end

endmodule
